/* hdl/psl_pins.sv */
// dual-use strap and indicator pins of the transceiver
`timescale 1ns/1ns
//
// Operation
// - Each dual-use pin is released to its pull and sampled after reset, then driven as an output.
// - Collision is driven after reset; its reset level selects the reduced interface.
// - The carrier pin's reset level sets back-to-back mode, valid only with the reduced interface.
// - The interrupt output's active level follows the polarity select input.
// - The interrupt pin's reset level is address bit 0.
// - A low level on the link/activity pin at reset enters factory test mode.
// - Link/activity is high with no link, low with link, toggling on traffic.
// - The speed pin's reset level loads the speed-select bit.
// - The speed indicator is active low and high at 10 Mb/s.
// - The receive data pins' reset levels are address bits 4 down to 1, with PIN_RXD0 giving bit 4.
module psl_pins #(
  parameter int ACT_BLINK_CYCLES = psl_pkg::ACT_BLINK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin levels seen from outside
  input wire logic [psl_pkg::PIN_COUNT-1:0] pin_in,
  // pin drivers
  output logic [psl_pkg::PIN_COUNT-1:0] pin_out,
  output logic [psl_pkg::PIN_COUNT-1:0] pin_oe,
  // core state to show on the pins
  input wire logic [3:0] rx_data,
  input wire logic collision,
  input wire logic carrier,
  input wire logic interrupt_event,
  input wire logic interrupt_active_high,
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  // captured configuration
  output logic strap_done,
  output logic rmii_select,
  output logic reduced_if_back_to_back,
  output logic [4:0] phy_address_strap,
  output logic test_mode,
  output logic speed_select
);
  import psl_pkg::*;

  psl_strap_if sif ();

  psl_strap_cap u_cap (
    .clk(clk),
    .rst(rst),
    .pin_in(pin_in),
    .sif(sif.cap)
  );

  logic [PIN_COUNT-1:0] out_ff;
  logic [PIN_COUNT-1:0] nxt_out;
  logic [PIN_COUNT-1:0] oe_ff;
  logic [PIN_COUNT-1:0] nxt_oe;
  logic done_ff;
  logic rmii_ff;
  logic btb_ff;
  logic [4:0] addr_ff;
  logic test_ff;
  logic spd_sel_ff;
  logic [31:0] blink_ff;
  logic [31:0] nxt_blink;
  logic blink_lvl_ff;
  logic nxt_blink_lvl;

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_comb begin
    nxt_out = PIN_SYNC_RESET;
    nxt_oe = {PIN_COUNT{sif.run}};
    nxt_blink = blink_ff;
    nxt_blink_lvl = blink_lvl_ff;
    // activity blink timer
    if (link_up && activity) begin
      if (blink_ff >= 32'(ACT_BLINK_CYCLES - 1)) begin
        nxt_blink = BLINK_CNT_RESET;
        nxt_blink_lvl = ~blink_lvl_ff;
      end else begin
        nxt_blink = blink_ff + 32'h1;
      end
    end else begin
      nxt_blink = BLINK_CNT_RESET;
      nxt_blink_lvl = 1'b0;
    end
    if (sif.run) begin
      nxt_out[PIN_RXD3:PIN_RXD0] = rx_data;
      nxt_out[PIN_COL] = collision;
      nxt_out[PIN_CRS] = carrier;
      nxt_out[PIN_INT] = interrupt_event ? interrupt_active_high
                                         : ~interrupt_active_high;
      if (!link_up) begin
        nxt_out[PIN_LINK] = 1'b1;
      end else begin
        nxt_out[PIN_LINK] = activity ? nxt_blink_lvl : 1'b0;
      end
      nxt_out[PIN_SPEED] = ~speed_100;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ff <= PIN_SYNC_RESET;
      oe_ff <= PIN_SYNC_RESET;
      blink_ff <= BLINK_CNT_RESET;
      blink_lvl_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      blink_ff <= nxt_blink;
      blink_lvl_ff <= nxt_blink_lvl;
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      rmii_ff <= 1'b0;
      btb_ff <= 1'b0;
      addr_ff <= PHY_ADDR_RESET;
      test_ff <= 1'b0;
      spd_sel_ff <= 1'b0;
    end else begin
      done_ff <= sif.run;
      rmii_ff <= sif.straps.rmii_select;
      btb_ff <= sif.straps.back_to_back;
      addr_ff <= sif.straps.phy_address_strap;
      test_ff <= sif.run & ~sif.straps.link_activity_level;
      spd_sel_ff <= sif.straps.fast_speed_strap;
    end
  end

  assign pin_out = out_ff;
  assign pin_oe = oe_ff;
  assign strap_done = done_ff;
  assign rmii_select = rmii_ff;
  assign reduced_if_back_to_back = btb_ff;
  assign phy_address_strap = addr_ff;
  assign test_mode = test_ff;
  assign speed_select = spd_sel_ff;
endmodule

/* hdl/psl_pkg.sv */
// constants and types for the phy strap and indicator pin block
package psl_pkg;
  // ----------------------------------------
  // pin vector layout of the dual-use pins
  // ----------------------------------------
  localparam int PIN_RXD0 = 0;
  localparam int PIN_RXD3 = 3;
  localparam int PIN_COL = 4;
  localparam int PIN_CRS = 5;
  localparam int PIN_INT = 6;
  localparam int PIN_LINK = 7;
  localparam int PIN_SPEED = 8;
  localparam int PIN_COUNT = 9;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STRAP_HOLD_CYCLES = 3;
  localparam logic [1:0] STRAP_CNT_RESET = 2'h0;
  localparam longint ACT_BLINK_NS = 64000000;
  localparam int ACT_BLINK_CYCLES = int'(ACT_BLINK_NS / CLK_PERIOD_NS);
  localparam logic [31:0] BLINK_CNT_RESET = 32'h0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [PIN_COUNT-1:0] PIN_SYNC_RESET = 9'h0;
  localparam logic [4:0] PHY_ADDR_RESET = 5'h0;
  localparam logic [3:0] RXD_RESET = 4'h0;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic {PH_STRAP, PH_RUN} psl_phase_type;
  typedef struct packed {
    logic rmii_select;
    logic back_to_back;
    logic [4:0] phy_address_strap;
    logic link_activity_level;
    logic fast_speed_strap;
  } psl_strap_type;
  localparam psl_strap_type STRAP_RESET = 9'h0;
endpackage

/* hdl/psl_strap_if.sv */
// strap values handed from the capture module to the pin logic
`timescale 1ns/1ns
interface psl_strap_if;
  import psl_pkg::*;
  logic run;
  psl_strap_type straps;
  modport cap (output run, output straps);
  modport use_side (input run, input straps);
endinterface

/* hdl/psl_strap_cap.sv */
// strap capture: pin synchroniser, hold phase and latched strap values
`timescale 1ns/1ns
module psl_strap_cap (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pin levels
  input wire logic [psl_pkg::PIN_COUNT-1:0] pin_in,
  // captured straps
  psl_strap_if.cap sif
);
  import psl_pkg::*;

  logic [PIN_COUNT-1:0] sync1_ff;
  logic [PIN_COUNT-1:0] sync2_ff;
  psl_phase_type phase_ff;
  psl_phase_type nxt_phase;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  psl_strap_type strap_ff;
  psl_strap_type nxt_strap;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_strap = strap_ff;
    case (phase_ff)
      PH_STRAP: begin
        // pins float on their pulls while sampled
        if (cnt_ff == 2'(STRAP_HOLD_CYCLES - 1)) begin
          nxt_phase = PH_RUN;
          nxt_strap.rmii_select = sync2_ff[PIN_COL];
          nxt_strap.back_to_back = sync2_ff[PIN_CRS] & sync2_ff[PIN_COL];
          nxt_strap.phy_address_strap[0] = sync2_ff[PIN_INT];
          nxt_strap.phy_address_strap[4:1] = {sync2_ff[PIN_RXD0], sync2_ff[1],
                                               sync2_ff[2], sync2_ff[PIN_RXD3]};
          nxt_strap.link_activity_level = sync2_ff[PIN_LINK];
          nxt_strap.fast_speed_strap = sync2_ff[PIN_SPEED];
        end else begin
          nxt_cnt = cnt_ff + 2'h1;
        end
      end
      PH_RUN: begin
        // straps frozen until the next reset
        nxt_phase = PH_RUN;
      end
      default: begin
        nxt_phase = PH_STRAP;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= PIN_SYNC_RESET;
      sync2_ff <= PIN_SYNC_RESET;
      phase_ff <= PH_STRAP;
      cnt_ff <= STRAP_CNT_RESET;
      strap_ff <= STRAP_RESET;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      strap_ff <= nxt_strap;
    end
  end

  assign sif.run = (phase_ff == PH_RUN);
  assign sif.straps = strap_ff;
endmodule

/* verif/psl_pins_monitor.sv */
// assertion checker for the strap and indicator pin block
`timescale 1ns/1ns
module psl_pins_monitor #(
  parameter int ACT_BLINK_CYCLES = psl_pkg::ACT_BLINK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe,
  // core state
  input wire logic [3:0] rx_data,
  input wire logic collision,
  input wire logic carrier,
  input wire logic interrupt_event,
  input wire logic interrupt_active_high,
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  // straps
  input wire logic strap_done,
  input wire logic rmii_select,
  input wire logic reduced_if_back_to_back,
  input wire logic [4:0] phy_address_strap,
  input wire logic test_mode,
  input wire logic speed_select
);
  import psl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // pin drive after capture
  // ----
  sequence s_run;
    strap_done ##1 strap_done;
  endsequence
  property p_oe;
    pin_oe == (strap_done ? 9'h1FF : 9'h000);
  endproperty
  property p_rxd;
    s_run |-> pin_out[3:0] == $past(rx_data);
  endproperty
  property p_col;
    s_run |-> pin_out[PIN_COL] == $past(collision);
  endproperty
  property p_crs;
    s_run |-> pin_out[PIN_CRS] == $past(carrier);
  endproperty
  property p_int;
    s_run |-> pin_out[PIN_INT] == ($past(interrupt_event) ~^ $past(interrupt_active_high));
  endproperty
  property p_link;
    s_run |-> ($past(link_up) ? ($past(activity) || !pin_out[PIN_LINK]) : pin_out[PIN_LINK]);
  endproperty
  property p_spd;
    s_run |-> pin_out[PIN_SPEED] == !$past(speed_100);
  endproperty
  property p_btb;
    reduced_if_back_to_back |-> rmii_select;
  endproperty
  property p_hold;
    s_run |-> $stable({rmii_select, reduced_if_back_to_back, phy_address_strap, test_mode,
      speed_select});
  endproperty
  property p_quiet;
    !strap_done |-> pin_out == 9'h000;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  a_rxd: assert property (p_rxd) else $error("rxd drive wrong");
  a_col: assert property (p_col) else $error("col drive wrong");
  a_crs: assert property (p_crs) else $error("crs drive wrong");
  a_int: assert property (p_int) else $error("int level wrong");
  a_link: assert property (p_link) else $error("link led wrong");
  a_spd: assert property (p_spd) else $error("speed led wrong");
  a_btb: assert property (p_btb) else $error("b2b without rmii");
  a_hold: assert property (p_hold) else $error("strap moved");
  a_quiet: assert property (p_quiet) else $error("pin driven in strap phase");
endmodule
bind psl_pins psl_pins_monitor #(.ACT_BLINK_CYCLES(ACT_BLINK_CYCLES)) mon_u (
  .clk(clk),
  .rst(rst),
  .pin_out(pin_out),
  .pin_oe(pin_oe),
  .rx_data(rx_data),
  .collision(collision),
  .carrier(carrier),
  .interrupt_event(interrupt_event),
  .interrupt_active_high(interrupt_active_high),
  .link_up(link_up),
  .activity(activity),
  .speed_100(speed_100),
  .strap_done(strap_done),
  .rmii_select(rmii_select),
  .reduced_if_back_to_back(reduced_if_back_to_back),
  .phy_address_strap(phy_address_strap),
  .test_mode(test_mode),
  .speed_select(speed_select)
);

/* verif/psl_pin_model.sv */
// board model: pulls hold the strap levels wherever the device lets go
`timescale 1ns/1ns
module psl_pin_model (
  // pulls and device drive
  input wire logic [8:0] pull,
  input wire logic [8:0] pin_out,
  input wire logic [8:0] pin_oe,
  // resolved levels
  output logic [8:0] pin_in
);
  // ----
  // released pins fall to their pull; driven pins show the device level
  // ----
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule

/* verif/psl_pins_tb.sv */
// self-checking bench for the strap and indicator pin block
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module psl_pins_tb;
  import psl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] pull = 9'h000;
  logic [8:0] pin_in, pin_out, pin_oe, m;
  logic [3:0] rx_data = 4'h0;
  logic collision = 1'b0, carrier = 1'b0, interrupt_event = 1'b0, interrupt_active_high = 1'b0;
  logic link_up = 1'b0, activity = 1'b0, speed_100 = 1'b0;
  logic strap_done, rmii_select, reduced_if_back_to_back, test_mode, speed_select;
  logic [4:0] phy_address_strap;
  logic [31:0] seed = 32'h38D5, r;
  logic [8:0] corner [4] = '{9'h000, 9'h1FF, 9'h030, 9'h020};
  logic [1:0] seen;
  int error_cnt = 0, check_count = 0, k;
  psl_pin_model model_u (.pull(pull), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  psl_pins #(.ACT_BLINK_CYCLES(4)) dut_u (
    .clk(clk),
    .rst(rst),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .rx_data(rx_data),
    .collision(collision),
    .carrier(carrier),
    .interrupt_event(interrupt_event),
    .interrupt_active_high(interrupt_active_high),
    .link_up(link_up),
    .activity(activity),
    .speed_100(speed_100),
    .strap_done(strap_done),
    .rmii_select(rmii_select),
    .reduced_if_back_to_back(reduced_if_back_to_back),
    .phy_address_strap(phy_address_strap),
    .test_mode(test_mode),
    .speed_select(speed_select)
  );
  initial begin
    forever #4 clk = ~clk;
  end
  // ----
  // expectations and helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [8:0] exp_pins();
    return {~speed_100, ~link_up, interrupt_event ~^ interrupt_active_high, carrier, collision,
      rx_data};
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check_straps();
    `CHK("rmii", pull[PIN_COL], rmii_select)
    `CHK("b2b", pull[PIN_CRS] & pull[PIN_COL], reduced_if_back_to_back)
    `CHK("addr", {pull[0], pull[1], pull[2], pull[3], pull[PIN_INT]}, phy_address_strap)
    `CHK("test", ~pull[PIN_LINK], test_mode)
    `CHK("speed", pull[PIN_SPEED], speed_select)
  endtask
  task automatic boot(input logic [8:0] p);
    pull <= p;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    k = 0;
    while (strap_done !== 1'b1 && k < 20) begin
      `CHK("oe_strap", 9'h000, pin_oe)
      `CHK("out_strap", 9'h000, pin_out)
      @(negedge clk);
      k++;
    end
    if (strap_done !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    `CHK("done_lat", STRAP_HOLD_CYCLES + 2, k)
    check_straps();
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    for (int s = 0; s < 7; s++) begin
      r = xs();
      @(posedge clk);
      boot(s < 4 ? corner[s] : r[8:0]);
      for (int i = 0; i < 12; i++) begin
        r = xs();
        @(posedge clk);
        {rx_data, collision, carrier, interrupt_event, interrupt_active_high, link_up, activity,
          speed_100} <= r[10:0];
        repeat (3) @(posedge clk);
        #1;
        m = {1'b0, link_up & activity, 7'h00};
        `CHK("oe", 9'h1FF, pin_oe)
        `CHK("pins", exp_pins() | m, pin_out | m)
      end
      check_straps();
    end
    @(posedge clk);
    link_up <= 1'b1;
    activity <= 1'b1;
    seen = 2'b00;
    repeat (12) begin
      @(negedge clk);
      seen[pin_out[PIN_LINK]] = 1'b1;
    end
    `CHK("blink", 2'b11, seen)
    conclude();
  end
endmodule
